// [inc/sie_pkg.sv]
/*
  Shared constants and types of the sector-0 instruction executor.
  Assumes a single 250 MHz clock domain and an APB register port.
*/
package sie_pkg;

  // ----------------------------------------------------------------
  // Timing and addresses
  // ----------------------------------------------------------------
  localparam int unsigned SIE_CLKS_PER_CYC = 4;
  localparam logic [7:0]  SIE_PC_LOW_ADDR  = 8'h06;
  localparam logic [11:0] SIE_OFS_STATUS   = 12'h000;
  localparam logic [11:0] SIE_OFS_WREG     = 12'h004;
  localparam logic [11:0] SIE_OFS_TABLE_HI = 12'h008;
  localparam logic [11:0] SIE_OFS_CTRL     = 12'h00C;
  localparam int unsigned SIE_CTRL_IRQ     = 0;
  localparam int unsigned SIE_CTRL_SLEEP   = 1;
  localparam logic [7:0]  SIE_WREG_RST     = 8'h00;
  localparam logic [7:0]  SIE_TABLE_HIGH_BYTE_RST     = 8'h00;
  localparam logic        SIE_IRQ_RST      = 1'b0;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'b000000, OP_ADD = 6'b000001, OP_ADC = 6'b000010,
    OP_SUB = 6'b000011, OP_SBC = 6'b000100, OP_DECIMAL_ADJUST = 6'b000101,
    OP_AND = 6'b000110, OP_OR = 6'b000111, OP_XOR = 6'b001000,
    OP_INVERT = 6'b001001, OP_INC = 6'b001010, OP_DEC = 6'b001011,
    OP_ROT_R = 6'b001100, OP_ROT_L = 6'b001101, OP_ROT_RC = 6'b001110,
    OP_ROT_LC = 6'b001111, OP_MOV = 6'b010000, OP_BIT_CLR = 6'b010001,
    OP_BIT_SET = 6'b010010, OP_CLR = 6'b010011, OP_SET = 6'b010100,
    OP_SWAP = 6'b010101, OP_JMP = 6'b010110, OP_CALL = 6'b010111,
    OP_RET = 6'b011000, OP_RET_IMM = 6'b011001, OP_INTERRUPT_RETURN = 6'b011010,
    OP_SKIP_ZERO = 6'b011011, OP_ZERO_TEST_MOVE = 6'b011100,
    OP_SKIP_NONZERO = 6'b011101, OP_SKIP_BIT_ZERO = 6'b011110,
    OP_SKIP_BIT_ONE = 6'b011111, OP_INCR_SKIP_ZERO = 6'b100000,
    OP_DECR_SKIP_ZERO = 6'b100001, OP_TABLE_FETCH = 6'b100010,
    OP_WATCHDOG_CLEAR = 6'b100011, OP_HALT = 6'b100100
  } sie_op_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic powerdown_flag;
    logic watchdog_timeout_flag;
    logic chained_zero_flag;
    logic signed_compare_flag;
    logic signed_range_exceeded_flag;
    logic half_byte_carry;
    logic carry_flag;
    logic zero_flag;
  } sie_flags_t;

  localparam sie_flags_t SIE_FLAGS_RST = 8'h00;

  typedef struct packed {
    sie_op_t    op;
    logic       mem_dest;
    logic       use_imm;
    logic [7:0] addr;
    logic [2:0] bitsel;
    logic [7:0] imm;
  } sie_instr_t;

  typedef struct packed {
    sie_op_t    op;
    logic       skip;
    logic       redirect;
    logic       mem_wr;
    logic [7:0] pc_low_val;
    logic [1:0] cycles;
  } sie_result_t;

  localparam sie_result_t SIE_RESULT_RST = 19'h00000;

endpackage

// [core/sie_core.sv]
/*
  Sector-0 instruction executor: decodes one instruction, runs it over
  whole instruction cycles and commits results, flags and side effects.
  Assumes instructions come from logic on pclk, program memory answers
  one clock after its read strobe, and the wake pin is asynchronous.
*/
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01: Memory operands address only the 256-byte sector 0 array.
// RULE_02: Bit operations pick bit 0 to 7 by a 3-bit index.
// RULE_03: Additions take one cycle, update zero, carry, half carry, overflow, sign.
// RULE_04: Subtractions take one cycle, update those flags plus chained zero.
// RULE_05: Decimal adjust corrects the working register into memory, changes only carry.
// RULE_06: AND, OR, XOR, invert take one cycle and change only zero.
// RULE_07: Increment and decrement by one change only zero.
// RULE_08: Plain rotates keep flags; rotates through carry change only carry.
// RULE_09: Moves and single-bit set or clear take one cycle, no flags.
// RULE_10: Jump, call and all returns take two cycles and change no flag.
// RULE_11: Table fetch loads high byte to table register, low byte to memory, two cycles.
// RULE_12: Skips take one cycle without skip, more when skipping.
// RULE_13: Any write to program counter low takes two cycles.
// RULE_14: Watchdog clear restarts the watchdog and clears timeout and power-down flags.
// RULE_15: Halt enters power-down in one cycle and updates both watchdog flags.
// RULE_16: Nibble swap exchanges halves into memory or working register, no flags.
// RULE_17: Zero test move copies the byte to working register and skips on zero.
// RULE_18: Increment or decrement skip stores the result and skips on zero.
// RULE_19: One instruction cycle is four clock periods.
// RULE_20: Interrupt return sets global interrupt enable; plain return leaves it.
// RULE_21: Register-destination forms keep memory; memory-destination forms keep register.
module sie_core
  import sie_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_valid,
  input  wire sie_instr_t  instr,
  output logic             instr_ready,
  output logic             done,
  output sie_result_t      result,
  output logic             pm_rd,
  output logic      [15:0] pm_addr,
  input  wire logic [15:0] pm_data,
  input  wire logic        wake_pin,
  input  wire logic        wdt_expired,
  output logic             wdt_restart,
  output sie_flags_t       flags,
  output logic      [7:0]  working_register,
  output logic      [7:0]  table_high_byte,
  output logic             global_irq_enable,
  output logic             sleep_mode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  dmem [256];
  logic        busy, tab_cap, wake_meta, wake_sync;
  logic [2:0]  clk_cnt;
  logic [7:0]  pend_wreg, pend_mem, pend_addr, pend_table_high_byte;
  logic        pend_wwe, pend_tab, pend_wdt, pend_halt, pend_interrupt_return_op;
  sie_flags_t  pend_flags;
  sie_result_t pend_res;
  logic [7:0]  m, b, bb, r, nw, nm;
  logic [8:0]  s9, d9a, d9b;
  logic [4:0]  h5;
  logic        cin, sub, alu, zupd, wwe, mwe, skip, two, rdir;
  logic        wdt, hlt, interrupt_return_op, tab;
  sie_flags_t  nf;
  logic [1:0]  ncyc;
  logic        take, commit, apb_wr, mapped;
  logic [31:0] rd_mux;

  assign take   = ce & instr_valid & instr_ready;
  assign commit = ce & busy & (clk_cnt == 3'h0);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    m    = dmem[instr.addr];                                     // [RULE_01]
    b    = instr.use_imm ? instr.imm : m;
    sub  = instr.op inside {OP_SUB, OP_SBC};
    bb   = sub ? ~b : b;
    cin  = (instr.op == OP_SUB) |
           ((instr.op inside {OP_ADC, OP_SBC}) & flags.carry_flag);
    s9   = {1'b0, working_register} + {1'b0, bb} + {8'h00, cin};
    h5   = {1'b0, working_register[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    d9a  = {1'b0, working_register} +
           ((working_register[3:0] > 4'h9 || flags.half_byte_carry) ? 9'h006 : 9'h000);
    d9b  = d9a + ((d9a[7:4] > 4'h9 || d9a[8] || flags.carry_flag) ? 9'h060 : 9'h000);
    r    = m;
    nw   = working_register;
    nm   = m;
    nf   = flags;
    alu  = 1'b0;
    zupd = 1'b0;
    wwe  = 1'b0;
    mwe  = 1'b0;
    skip = 1'b0;
    two  = 1'b0;
    rdir = 1'b0;
    wdt  = 1'b0;
    hlt  = 1'b0;
    interrupt_return_op = 1'b0;
    tab  = 1'b0;
    unique case (instr.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin                      // [RULE_03] [RULE_04]
        r    = s9[7:0];
        alu  = 1'b1;
        zupd = 1'b1;
        nf.carry_flag = s9[8];
        nf.half_byte_carry = h5[4];
        nf.signed_range_exceeded_flag =
          (working_register[7] == bb[7]) && (r[7] != working_register[7]);
        nf.signed_compare_flag = ~(nf.signed_range_exceeded_flag ^ r[7]);
        if (sub) begin
          nf.chained_zero_flag = (r == 8'h00) &
            ((instr.op == OP_SUB) | flags.chained_zero_flag);
        end
      end
      OP_DECIMAL_ADJUST: begin                                   // [RULE_05]
        nm  = d9b[7:0];
        mwe = 1'b1;
        nf.carry_flag = flags.carry_flag | d9a[8] | d9b[8];
      end
      OP_AND, OP_OR, OP_XOR, OP_INVERT: begin                    // [RULE_06]
        alu  = 1'b1;
        zupd = 1'b1;
        unique case (instr.op)
          OP_AND:  r = working_register & b;
          OP_OR:   r = working_register | b;
          OP_XOR:  r = working_register ^ b;
          default: r = ~m;
        endcase
      end
      OP_INC, OP_DEC: begin                                      // [RULE_07]
        alu  = 1'b1;
        zupd = 1'b1;
        r    = (instr.op == OP_INC) ? m + 8'h01 : m - 8'h01;
      end
      OP_ROT_R: begin                                            // [RULE_08]
        alu = 1'b1;
        r   = {m[0], m[7:1]};
      end
      OP_ROT_L: begin                                            // [RULE_08]
        alu = 1'b1;
        r   = {m[6:0], m[7]};
      end
      OP_ROT_RC: begin                                           // [RULE_08]
        alu = 1'b1;
        r   = {flags.carry_flag, m[7:1]};
        nf.carry_flag = m[0];
      end
      OP_ROT_LC: begin                                           // [RULE_08]
        alu = 1'b1;
        r   = {m[6:0], flags.carry_flag};
        nf.carry_flag = m[7];
      end
      OP_SWAP: begin                                             // [RULE_16]
        alu = 1'b1;
        r   = {m[3:0], m[7:4]};
      end
      OP_MOV: begin                                              // [RULE_09]
        if (instr.mem_dest) begin
          nm  = working_register;
          mwe = 1'b1;
        end else begin
          nw  = b;
          wwe = 1'b1;
        end
      end
      OP_BIT_CLR, OP_BIT_SET: begin                              // [RULE_02] [RULE_09]
        nm[instr.bitsel] = (instr.op == OP_BIT_SET);
        mwe = 1'b1;
      end
      OP_CLR, OP_SET: begin
        nm  = (instr.op == OP_SET) ? 8'hFF : 8'h00;
        mwe = 1'b1;
      end
      OP_JMP, OP_CALL, OP_RET: begin                             // [RULE_10]
        two  = 1'b1;
        rdir = 1'b1;
      end
      OP_RET_IMM: begin                                          // [RULE_10]
        two  = 1'b1;
        rdir = 1'b1;
        nw   = instr.imm;
        wwe  = 1'b1;
      end
      OP_INTERRUPT_RETURN: begin                                 // [RULE_10] [RULE_20]
        two  = 1'b1;
        rdir = 1'b1;
        interrupt_return_op = 1'b1;
      end
      OP_SKIP_ZERO:     skip = (m == 8'h00);                     // [RULE_12]
      OP_SKIP_NONZERO:  skip = (m != 8'h00);
      OP_SKIP_BIT_ZERO: skip = ~m[instr.bitsel];                 // [RULE_02]
      OP_SKIP_BIT_ONE:  skip = m[instr.bitsel];
      OP_ZERO_TEST_MOVE: begin                                   // [RULE_17]
        nw   = m;
        wwe  = 1'b1;
        skip = (m == 8'h00);
      end
      OP_INCR_SKIP_ZERO, OP_DECR_SKIP_ZERO: begin                // [RULE_18]
        alu  = 1'b1;
        r    = (instr.op == OP_INCR_SKIP_ZERO) ? m + 8'h01 : m - 8'h01;
        skip = (r == 8'h00);
      end
      OP_TABLE_FETCH: begin                                      // [RULE_11]
        two = 1'b1;
        tab = 1'b1;
        mwe = 1'b1;
      end
      OP_WATCHDOG_CLEAR: wdt = 1'b1;                             // [RULE_14]
      OP_HALT:           hlt = 1'b1;                             // [RULE_15]
      OP_NOP:            ;
      default:           ;
    endcase
    if (zupd) begin
      nf.zero_flag = (r == 8'h00);
    end
    if (alu) begin                                               // [RULE_21]
      if (instr.mem_dest) begin
        nm  = r;
        mwe = 1'b1;
      end else begin
        nw  = r;
        wwe = 1'b1;
      end
    end
    if (mwe && instr.addr == SIE_PC_LOW_ADDR) begin              // [RULE_13]
      two  = 1'b1;
      rdir = 1'b1;
    end
    ncyc = (two | skip) ? 2'd2 : 2'd1;                           // [RULE_12]
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Commit lands on the last clock of the last instruction cycle, so
  // the next take sees committed state with no bypass path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      clk_cnt    <= 3'h0;
      pend_wreg  <= 8'h00;
      pend_mem   <= 8'h00;
      pend_addr  <= 8'h00;
      pend_table_high_byte  <= 8'h00;
      pend_wwe   <= 1'b0;
      pend_tab   <= 1'b0;
      pend_wdt   <= 1'b0;
      pend_halt  <= 1'b0;
      pend_interrupt_return_op  <= 1'b0;
      pend_flags <= SIE_FLAGS_RST;
      pend_res   <= SIE_RESULT_RST;
      pm_addr    <= 16'h0000;
      pm_rd      <= 1'b0;
      tab_cap    <= 1'b0;
    end else if (ce) begin
      pm_rd   <= take & tab;
      tab_cap <= pm_rd;
      if (take) begin
        busy       <= 1'b1;
        clk_cnt    <= 3'(SIE_CLKS_PER_CYC * ncyc - 2);           // [RULE_19]
        pend_wreg  <= nw;
        pend_mem   <= nm;
        pend_addr  <= instr.addr;
        pend_wwe   <= wwe;
        pend_tab   <= tab;
        pend_wdt   <= wdt;
        pend_halt  <= hlt;
        pend_interrupt_return_op  <= interrupt_return_op;
        pend_flags <= nf;
        pend_res   <= '{op: instr.op, skip: skip, redirect: rdir, mem_wr: mwe,
                        pc_low_val: nm, cycles: ncyc};
        pm_addr    <= {instr.imm, working_register};
      end else if (busy) begin
        clk_cnt <= clk_cnt - 3'h1;
        if (commit) begin
          busy <= 1'b0;
        end
      end
      if (tab_cap) begin                                         // [RULE_11]
        pend_mem  <= pm_data[7:0];
        pend_table_high_byte <= pm_data[15:8];
      end
    end
  end

  // Data array has no reset; software initialises what it uses
  always_ff @(posedge pclk) begin
    if (commit && pend_res.mem_wr) begin                         // [RULE_21]
      dmem[pend_addr] <= pend_mem;
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register <= SIE_WREG_RST;
      table_high_byte  <= SIE_TABLE_HIGH_BYTE_RST;
    end else if (ce) begin
      if (commit && pend_wwe) begin                              // [RULE_21]
        working_register <= pend_wreg;
      end else if (apb_wr && paddr == SIE_OFS_WREG && !busy) begin
        working_register <= pwdata[7:0];
      end
      if (commit && pend_tab) begin                              // [RULE_11]
        table_high_byte <= pend_table_high_byte;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= SIE_FLAGS_RST;
    end else if (ce) begin
      if (commit) begin
        flags.zero_flag                  <= pend_flags.zero_flag;
        flags.carry_flag                 <= pend_flags.carry_flag;
        flags.half_byte_carry            <= pend_flags.half_byte_carry;
        flags.signed_range_exceeded_flag <= pend_flags.signed_range_exceeded_flag;
        flags.signed_compare_flag        <= pend_flags.signed_compare_flag;
        flags.chained_zero_flag          <= pend_flags.chained_zero_flag;
      end
      // Expiry wins over a clear landing in the same clock
      if (wdt_expired) begin
        flags.watchdog_timeout_flag <= 1'b1;
      end else if (commit && (pend_wdt || pend_halt)) begin      // [RULE_14] [RULE_15]
        flags.watchdog_timeout_flag <= 1'b0;
      end
      if (commit && pend_wdt) begin                              // [RULE_14]
        flags.powerdown_flag <= 1'b0;
      end else if (commit && pend_halt) begin                    // [RULE_15]
        flags.powerdown_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else if (ce) begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ready       <= 1'b1;
      sleep_mode        <= 1'b0;
      done              <= 1'b0;
      result            <= SIE_RESULT_RST;
      wdt_restart       <= 1'b0;
      global_irq_enable <= SIE_IRQ_RST;
    end else if (ce) begin
      done        <= commit;
      wdt_restart <= commit & pend_wdt;                          // [RULE_14]
      if (commit) begin
        result <= pend_res;
      end
      if (take) begin
        instr_ready <= 1'b0;
      end else if (commit) begin
        instr_ready <= ~pend_halt;
        sleep_mode  <= pend_halt;                                // [RULE_15]
      end else if (sleep_mode && (wake_sync || wdt_expired)) begin
        instr_ready <= 1'b1;
        sleep_mode  <= 1'b0;
      end
      if (commit && pend_interrupt_return_op) begin                             // [RULE_20]
        global_irq_enable <= 1'b1;
      end else if (apb_wr && paddr == SIE_OFS_CTRL) begin
        global_irq_enable <= pwdata[SIE_CTRL_IRQ];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state; writes take effect on the edge that samples pready
  assign apb_wr = ce & psel & penable & pready & pwrite & mapped;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr)
      SIE_OFS_STATUS: rd_mux[7:0] = flags;
      SIE_OFS_WREG:   rd_mux[7:0] = working_register;
      SIE_OFS_TABLE_HI: rd_mux[7:0] = table_high_byte;
      SIE_OFS_CTRL: begin
        rd_mux[SIE_CTRL_IRQ]   = global_irq_enable;
        rd_mux[SIE_CTRL_SLEEP] = sleep_mode;
      end
      default:        mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= rd_mux;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] exec_clks;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_clks <= 4'h0;
    end else if (ce) begin
      if (take) begin
        exec_clks <= 4'h0;
      end else if (busy) begin
        exec_clks <= exec_clks + 4'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_take;
    instr_valid && instr_ready && ce;
  endsequence

  sequence s_done(sie_op_t o);
    done && result.op == o;
  endsequence

  chk_take_busy: assert property (s_take |=> busy && !instr_ready) // [RULE_19]
    else $error("Taken instruction did not start");
  chk_cycle_len: assert property (done |->                     // [RULE_19]
    int'(exec_clks) == SIE_CLKS_PER_CYC * int'(result.cycles) - 1)
    else $error("Instruction length not four clocks per cycle");
  chk_logic_flags: assert property (                           // [RULE_06]
    done && result.op inside {OP_AND, OP_OR, OP_XOR, OP_INVERT} |->
    flags[7:1] == $past(flags[7:1]))
    else $error("Logic operation touched a flag other than zero");
  chk_move_flags: assert property (                            // [RULE_09]
    done && result.op inside {OP_MOV, OP_BIT_CLR, OP_BIT_SET} && !$past(wdt_expired) |->
    flags == $past(flags) && result.cycles == (result.redirect ? 2'd2 : 2'd1))
    else $error("Move changed flags or took wrong length");
  chk_branch_len: assert property (                            // [RULE_10]
    done && result.op inside {OP_JMP, OP_CALL, OP_RET, OP_RET_IMM, OP_INTERRUPT_RETURN} |->
    result.cycles == 2'd2 && flags[5:0] == $past(flags[5:0]))
    else $error("Branch not two cycles or changed a flag");
  chk_skip_len: assert property (done && result.skip |-> result.cycles == 2'd2) // [RULE_12]
    else $error("Skip did not add one cycle");
  chk_pc_low_extra: assert property (                          // [RULE_13]
    done && result.mem_wr && $past(pend_addr) == SIE_PC_LOW_ADDR |->
    result.cycles == 2'd2 && result.redirect)
    else $error("Program counter low write not two cycles");
  chk_wdt_clear: assert property (                             // [RULE_14]
    s_done(OP_WATCHDOG_CLEAR) && !$past(wdt_expired) |->
    wdt_restart && !flags.watchdog_timeout_flag && !flags.powerdown_flag)
    else $error("Watchdog clear did not clear flags");
  chk_halt_sleep: assert property (                            // [RULE_15]
    s_done(OP_HALT) |-> flags.powerdown_flag && sleep_mode && !instr_ready)
    else $error("Halt did not enter power-down");
  chk_interrupt_return_op_irq: assert property (s_done(OP_INTERRUPT_RETURN) |-> global_irq_enable) // [RULE_20]
    else $error("Interrupt return left interrupts disabled");
  chk_acc_keep: assert property (                              // [RULE_21]
    done && result.mem_wr && result.op != OP_RET_IMM |->
    working_register == $past(working_register))
    else $error("Memory-destination form changed working register");

endmodule

`default_nettype wire

// [verification/sie_pm_model.sv]
/*
  Program memory model for the table fetch path.
  Assumes the word is wanted one clock after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module sie_pm_model (
  input  wire logic        pclk,
  input  wire logic        pm_rd,
  input  wire logic [15:0] pm_addr,
  output logic      [15:0] pm_data
);
  initial pm_data = 16'h0000;
  // Outside the answer cycle the bus toggles, so a late sample is seen
  always @(posedge pclk) pm_data <= pm_rd ? {pm_addr[7:0] ^ 8'hA5, pm_addr[15:8]} : ~pm_data;
endmodule
`default_nettype wire

// [verification/sie_core_tb.sv]
/*
  Self-checking bench of the sector-0 executor.
  Assumes the program memory model answers table fetches.
*/
`timescale 1ns/1ps
`default_nettype none
module sie_core_tb;
  import sie_pkg::*;
  typedef struct packed {sie_op_t o; logic md, ui; logic [7:0] a, im, w; logic z; int c;} sie_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, er, instr_ready, done, pm_rd, wdt_restart, irq, sleep_mode;
  logic wdt_expired = 0;
  sie_instr_t instr = '0;
  sie_result_t result;
  sie_flags_t flags;
  logic [15:0] pm_addr, pm_data;
  logic [7:0] wreg, tbl_high;
  int err_total = 0, n_checks = 0, cyc = 0, n;
  sie_row_t rows[17] = '{
    '{OP_MOV, 0, 1, 8'h00, 8'h3C, 8'h3C, 0, 1}, '{OP_MOV, 1, 0, 8'h10, 8'h00, 8'h3C, 0, 1},
    '{OP_ADD, 0, 1, 8'h00, 8'hC4, 8'h00, 1, 1}, '{OP_INC, 0, 0, 8'h10, 8'h00, 8'h3D, 0, 1},
    '{OP_SWAP, 0, 0, 8'h10, 8'h00, 8'hC3, 0, 1},
    '{OP_ZERO_TEST_MOVE, 0, 0, 8'h10, 8'h00, 8'h3C, 0, 1},
    '{OP_JMP, 0, 0, 8'h00, 8'h00, 8'h3C, 0, 2}, '{OP_MOV, 1, 0, 8'h06, 8'h00, 8'h3C, 0, 2},
    '{OP_CLR, 1, 0, 8'h11, 8'h00, 8'h3C, 0, 1},
    '{OP_ZERO_TEST_MOVE, 0, 0, 8'h11, 8'h00, 8'h00, 0, 2},
    '{OP_TABLE_FETCH, 0, 0, 8'h12, 8'h05, 8'h00, 0, 2},
    '{OP_MOV, 0, 0, 8'h12, 8'h00, 8'h05, 0, 1},
    '{OP_AND, 0, 1, 8'h00, 8'h0A, 8'h00, 1, 1}, '{OP_SUB, 0, 1, 8'h00, 8'h01, 8'hFF, 0, 1},
    '{OP_ROT_LC, 0, 0, 8'h12, 8'h00, 8'h0A, 0, 1},
    '{OP_DECR_SKIP_ZERO, 1, 0, 8'h11, 8'h00, 8'h0A, 0, 1},
    '{OP_INCR_SKIP_ZERO, 0, 0, 8'h11, 8'h00, 8'h00, 0, 2}};
  sie_core u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .done(done), .result(result), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data),
    .wake_pin(1'b0), .wdt_expired(wdt_expired), .wdt_restart(wdt_restart), .flags(flags),
    .working_register(wreg), .table_high_byte(tbl_high), .global_irq_enable(irq),
    .sleep_mode(sleep_mode));
  sie_pm_model u_pm (.pclk(pclk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));
  always #2 pclk = ~pclk;
  // Hang guard well above the under two hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Counts edges from take to done, so n is four times the cycle count
  task automatic op(input sie_op_t o, input logic md, ui, input logic [7:0] a, im);
    @(posedge pclk);
    instr_valid <= 1;
    instr <= '{o, md, ui, a, 3'h0, im};
    do @(posedge pclk); while (instr_ready !== 1'b1);
    instr_valid <= 0;
    n = 0;
    do begin @(posedge pclk); n++; end while (done !== 1'b1 && n < 20);
  endtask
  task automatic apb(input logic w, input logic [11:0] a);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({instr_ready, irq, wreg, flags}, 18'h20000);
    foreach (rows[i]) begin
      op(rows[i].o, rows[i].md, rows[i].ui, rows[i].a, rows[i].im);
      chk(wreg, rows[i].w);
      chk(flags.zero_flag, rows[i].z);
      chk(n, 4 * rows[i].c);
      chk({result.op, result.cycles}, {rows[i].o, 2'(rows[i].c)});
    end
    chk(tbl_high, 8'hA5);
    op(OP_INTERRUPT_RETURN, 0, 0, 8'h00, 8'h00);
    apb(0, SIE_OFS_CTRL);
    chk(rd, 32'h00000001);
    apb(0, 12'h010);
    chk(er, 1'b1);
    op(OP_HALT, 0, 0, 8'h00, 8'h00);
    chk({sleep_mode, flags[7:6], n[3:0]}, 7'h64);
    wdt_expired <= 1;
    @(posedge pclk) wdt_expired <= 0;
    repeat (4) @(posedge pclk);
    chk({instr_ready, flags[7:6]}, 3'b111);
    op(OP_WATCHDOG_CLEAR, 0, 0, 8'h00, 8'h00);
    chk({wdt_restart, flags[7:6], n[3:0]}, 7'h44);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk({instr_ready, sleep_mode, irq, wreg, tbl_high, flags}, 27'h4000000);
    results();
  end
endmodule
`default_nettype wire
